//--- lcx_codec.sv
// Lane symbol codec: 8B/10B encoder, decoder and parallel loopback.
// Assumes one lane clock; symbols from the deserialiser and the loopback
// control come from logic on that clock, so no synchroniser is used.
`timescale 1ns/1ps
module lcx_codec
	import lcx_pkg::*;
#(
	parameter bit LPBK_PRESENT = 1'b1
) (
	// Clock and reset.
	input  logic                 mclk,
	input  logic                 rst,
	// Characters to transmit.
	input  logic                 tx_valid,
	input  lcx_char_s            tx_char,
	// Symbols to the serialiser.
	output logic [LCX_SYM_W-1:0] tx_sym_ff,
	output logic                 tx_sym_valid_ff,
	output logic                 tx_rd_ff,
	// Symbols from the deserialiser.
	input  logic                 rx_sym_valid,
	input  logic [LCX_SYM_W-1:0] rx_sym,
	// Loopback control.
	input  logic                 lpbk_en,
	// Decoded characters and error events.
	output lcx_char_s            rx_char_ff,
	output logic                 rx_valid_ff,
	output logic                 rx_disp_err_ff,
	output logic                 rx_sym_err_ff,
	output logic                 rx_rd_ff
);

	lcx_code_s            tx_code;
	logic                 lpbk_active;
	logic                 src_valid;
	logic [LCX_SYM_W-1:0] src_sym;
	lcx_look_s            look;
	logic                 disp_err;
	logic                 sym_err;
	lcx_char_s            nxt_rx_char;
	logic                 nxt_rx_rd;
	int                   src_ones;

	// Transmit path.
	assign tx_code = lcx_encode(tx_char, tx_rd_ff);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_sym_ff <= '0;
			tx_sym_valid_ff <= 1'h0;
			tx_rd_ff <= LCX_RD_RST;
		end else begin
			tx_sym_valid_ff <= tx_valid;
			if (tx_valid) begin
				tx_sym_ff <= tx_code.sym;
				tx_rd_ff <= tx_code.rd;
			end
		end
	end

	// Loopback selection of the receive source.
	assign lpbk_active = LPBK_PRESENT && lpbk_en;
	assign src_valid = lpbk_active ? tx_sym_valid_ff : rx_sym_valid;
	assign src_sym = lpbk_active ? tx_sym_ff : rx_sym;

	// Receive path.
	lcx_dec_lut u_dec (
		.sym  (src_sym),
		.rd   (rx_rd_ff),
		.look (look)
	);

	assign sym_err = !look.valid;
	assign disp_err = look.valid && !look.rd_ok;
	assign nxt_rx_char = (sym_err || disp_err) ? LCX_ERR_CHAR
		: look.ch;
	assign src_ones = $countones(src_sym);
	// A faulty symbol still moves disparity, so the receiver resyncs to it.
	assign nxt_rx_rd = (src_ones > LCX_SYM_BAL) ? 1'h1 :
		(src_ones < LCX_SYM_BAL) ? 1'h0 : rx_rd_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_char_ff <= '0;
			rx_valid_ff <= 1'h0;
			rx_disp_err_ff <= 1'h0;
			rx_sym_err_ff <= 1'h0;
			rx_rd_ff <= LCX_RD_RST;
		end else begin
			rx_valid_ff <= src_valid;
			rx_disp_err_ff <= src_valid && disp_err;
			rx_sym_err_ff <= src_valid && sym_err;
			if (src_valid) begin
				rx_char_ff <= nxt_rx_char;
				rx_rd_ff <= nxt_rx_rd;
			end
		end
	end

	// Checks on the transmit path.
	a_tx_one_symbol: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid |=> tx_sym_valid_ff)
	else $error("valid character did not give one symbol");

	a_tx_no_spurious: assert property (
		@(posedge mclk) disable iff (rst)
		!tx_valid |=> !tx_sym_valid_ff)
	else $error("symbol sent without a character");

	a_tx_pos_to_neg: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && tx_rd_ff |=> $countones(tx_sym_ff) <= LCX_SYM_BAL)
	else $error("positive disparity gave a positive symbol");

	a_tx_neg_to_pos: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && !tx_rd_ff |=> $countones(tx_sym_ff) >= LCX_SYM_BAL)
	else $error("negative disparity gave a negative symbol");

	a_tx_rd_follow: assert property (
		@(posedge mclk) disable iff (rst)
		tx_sym_valid_ff |-> tx_rd_ff ==
			(($countones(tx_sym_ff) > LCX_SYM_BAL) ? 1'h1 :
			($countones(tx_sym_ff) < LCX_SYM_BAL) ? 1'h0 : $past(tx_rd_ff)))
	else $error("transmit disparity not updated from symbol");

	a_tx_rd_hold: assert property (
		@(posedge mclk) disable iff (rst)
		!tx_valid |=> $stable(tx_rd_ff) && $stable(tx_sym_ff))
	else $error("transmit state moved without a character");

	a_d00_first_block: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && !tx_char.k && tx_char.data[4:0] == 5'h00 && !tx_rd_ff
		|=> tx_sym_ff[9:4] == 6'h27)
	else $error("D00 from negative disparity has wrong 6b code");

	a_k28_distinct: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && tx_char.k && tx_char.data[4:0] == LCX_K28_X
		|=> tx_sym_ff[9:4] == (($past(tx_rd_ff)) ? 6'h30 : 6'h0f))
	else $error("K28 6b code wrong");

	a_x0_second_block: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && tx_char.data == 8'h00 && !tx_rd_ff
		|=> tx_sym_ff == 10'h274)
	else $error("D0.0 from negative disparity wrong");

	a_alt_seven: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && !tx_char.k && tx_char.data == 8'hf1 && !tx_rd_ff
		|=> tx_sym_ff[3:0] == LCX_4B_ALT)
	else $error("D17.7 did not use the alternate code");

	a_alt_seven_pos: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && !tx_char.k && tx_char.data == 8'heb && tx_rd_ff
		|=> tx_sym_ff[3:0] == ~LCX_4B_ALT)
	else $error("D11.7 did not use the alternate code");

	a_d07_primary: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && !tx_char.k && tx_char.data == 8'he0 && !tx_rd_ff
		|=> tx_sym_ff == 10'h271)
	else $error("D0.7 from negative disparity wrong");

	a_k285_from_neg: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && tx_char.k && tx_char.data == 8'hbc && !tx_rd_ff
		|=> tx_sym_ff == 10'h0fa)
	else $error("K28.5 from negative disparity wrong");

	a_k285_from_pos: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && tx_char.k && tx_char.data == 8'hbc && tx_rd_ff
		|=> tx_sym_ff == 10'h305)
	else $error("K28.5 from positive disparity wrong");

	a_d00_from_pos: assert property (
		@(posedge mclk) disable iff (rst)
		tx_valid && !tx_char.k && tx_char.data == 8'h00 && tx_rd_ff
		|=> tx_sym_ff == 10'h18b)
	else $error("D0.0 from positive disparity wrong");

	a_tx_sym_balance: assert property (
		@(posedge mclk) disable iff (rst)
		tx_sym_valid_ff |-> $countones(tx_sym_ff) >= LCX_SYM_BAL - 1
			&& $countones(tx_sym_ff) <= LCX_SYM_BAL + 1)
	else $error("transmitted symbol out of balance");

	// Checks on the receive path.
	a_rx_disp_k00: assert property (
		@(posedge mclk) disable iff (rst)
		rx_disp_err_ff |-> rx_valid_ff && rx_char_ff == LCX_ERR_CHAR
			&& !rx_sym_err_ff)
	else $error("disparity error without K0.0");

	a_rx_sym_k00: assert property (
		@(posedge mclk) disable iff (rst)
		rx_sym_err_ff |-> rx_valid_ff && rx_char_ff == LCX_ERR_CHAR)
	else $error("symbol error without K0.0");

	a_rx_rd_track: assert property (
		@(posedge mclk) disable iff (rst)
		src_valid && $countones(src_sym) > LCX_SYM_BAL && rx_rd_ff
		|=> rx_disp_err_ff || rx_sym_err_ff)
	else $error("second positive symbol not flagged");

	a_rx_rd_update: assert property (
		@(posedge mclk) disable iff (rst)
		src_valid && $countones(src_sym) == LCX_SYM_BAL
		|=> $stable(rx_rd_ff))
	else $error("neutral symbol moved receive disparity");

	a_rx_one_char: assert property (
		@(posedge mclk) disable iff (rst)
		src_valid |=> rx_valid_ff)
	else $error("received symbol gave no character");

	a_rx_no_spurious: assert property (
		@(posedge mclk) disable iff (rst)
		!src_valid |=> !rx_valid_ff && !rx_disp_err_ff
			&& !rx_sym_err_ff)
	else $error("character or error without a symbol");

	a_rx_err_exclusive: assert property (
		@(posedge mclk) disable iff (rst)
		!(rx_disp_err_ff && rx_sym_err_ff))
	else $error("both receive error flags high");

	a_rx_good_clean: assert property (
		@(posedge mclk) disable iff (rst)
		rx_valid_ff && rx_char_ff != LCX_ERR_CHAR
		|-> !rx_disp_err_ff && !rx_sym_err_ff)
	else $error("error flagged on a decoded character");

	a_rx_char_hold: assert property (
		@(posedge mclk) disable iff (rst)
		!src_valid |=> $stable(rx_char_ff) && $stable(rx_rd_ff))
	else $error("receive state moved without a symbol");

	a_rx_rd_pos: assert property (
		@(posedge mclk) disable iff (rst)
		src_valid && $countones(src_sym) > LCX_SYM_BAL
		|=> rx_rd_ff)
	else $error("positive symbol left disparity negative");

	a_rx_rd_neg: assert property (
		@(posedge mclk) disable iff (rst)
		src_valid && $countones(src_sym) < LCX_SYM_BAL
		|=> !rx_rd_ff)
	else $error("negative symbol left disparity positive");

	a_rx_rd_neg_err: assert property (
		@(posedge mclk) disable iff (rst)
		src_valid && $countones(src_sym) < LCX_SYM_BAL && !rx_rd_ff
		|=> rx_disp_err_ff || rx_sym_err_ff)
	else $error("second negative symbol not flagged");

	a_lpbk_route: assert property (
		@(posedge mclk) disable iff (rst)
		lpbk_active && tx_sym_valid_ff |=> rx_valid_ff)
	else $error("loopback symbol not received");

	a_lpbk_absent: assert property (
		@(posedge mclk) disable iff (rst)
		!lpbk_active && rx_sym_valid |=> rx_valid_ff)
	else $error("serial input ignored without loopback");

	a_lpbk_pins_off: assert property (
		@(posedge mclk) disable iff (rst)
		lpbk_active && !tx_sym_valid_ff |=> !rx_valid_ff)
	else $error("serial input received during loopback");

	// A data or legal control character looped back with matching disparity comes back unchanged.
	sequence s_lb_send;
		lpbk_active && tx_valid && (!tx_char.k || lcx_k_legal(tx_char));
	endsequence

	sequence s_lb_arrive;
		lpbk_active && rx_rd_ff == $past(tx_rd_ff);
	endsequence

	a_lpbk_roundtrip: assert property (
		@(posedge mclk) disable iff (rst)
		s_lb_send ##1 s_lb_arrive |=> rx_valid_ff && !rx_disp_err_ff
			&& !rx_sym_err_ff && rx_char_ff == $past(tx_char, 2))
	else $error("looped character not decoded back");

endmodule

//--- lcx_codec_test.sv
// Self-checking bench for the lane symbol codec.
// Assumes a 100 MHz lane clock and the deserialiser model beside it.
`timescale 1ns/1ps
module lcx_codec_test
	import lcx_pkg::*;
;
	localparam lcx_char_s c_d00 = '{1'h0, 8'h00};
	localparam lcx_char_s c_k285 = '{1'h1, 8'hbc};
	localparam lcx_char_s c_err = '{1'h1, 8'h00};
	logic                 mclk, rst, tx_valid, cmd_valid, lpbk_en;
	lcx_char_s            tx_char, rx_char_ff;
	logic [LCX_SYM_W-1:0] cmd_sym, rx_sym, tx_sym_ff;
	logic                 rx_sym_valid, tx_sym_valid_ff, tx_rd_ff;
	logic                 rx_valid_ff, rx_disp_err_ff, rx_sym_err_ff, rx_rd_ff;
	int                   n_errors, samples_checked, n_cycles;

	lcx_codec i_lcx_codec (.mclk(mclk), .rst(rst), .tx_valid(tx_valid),
		.tx_char(tx_char), .tx_sym_ff(tx_sym_ff),
		.tx_sym_valid_ff(tx_sym_valid_ff), .tx_rd_ff(tx_rd_ff),
		.rx_sym_valid(rx_sym_valid), .rx_sym(rx_sym), .lpbk_en(lpbk_en),
		.rx_char_ff(rx_char_ff), .rx_valid_ff(rx_valid_ff),
		.rx_disp_err_ff(rx_disp_err_ff), .rx_sym_err_ff(rx_sym_err_ff),
		.rx_rd_ff(rx_rd_ff));

	lcx_serdes_model i_lcx_serdes_model (.mclk(mclk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_sym(cmd_sym),
		.rx_sym_valid(rx_sym_valid), .rx_sym(rx_sym));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic tally_and_finish();
		$display("errors %0d, checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		n_cycles <= n_cycles + 1;
		if (n_cycles == 2000) begin
			n_errors++;
			$display("ERROR %0t: run did not finish", $time);
			tally_and_finish();
		end
	end

	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_sym(input logic [9:0] got, input logic [9:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: symbol %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_char(input lcx_char_s got, input lcx_char_s exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: char %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_tx(input logic v, input logic [9:0] s, input logic rd);
		chk_bit(tx_sym_valid_ff, v);
		chk_sym(tx_sym_ff, s);
		chk_bit(tx_rd_ff, rd);
	endtask

	task automatic chk_rx(input logic v, input lcx_char_s c, input logic de,
		input logic se, input logic rd);
		chk_bit(rx_valid_ff, v);
		chk_char(rx_char_ff, c);
		chk_bit(rx_disp_err_ff, de);
		chk_bit(rx_sym_err_ff, se);
		chk_bit(rx_rd_ff, rd);
	endtask

	// Drives one cycle at the edge, then lets that edge's updates settle.
	task automatic tick(input logic tv, input lcx_char_s tc, input logic rv,
		input logic [9:0] rs);
		@(posedge mclk);
		tx_valid <= tv;
		tx_char <= tc;
		cmd_valid <= rv;
		cmd_sym <= rs;
		#1;
	endtask

	task automatic do_reset();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
	endtask

	// Back-to-back characters with disparity chaining and both .7 forms.
	task automatic scen_tx();
		do_reset();
		tick(1'b1, c_d00, 1'b0, 10'h000);
		chk_tx(1'b0, 10'h000, 1'b0);
		tick(1'b1, c_k285, 1'b0, 10'h000);
		chk_tx(1'b1, 10'h274, 1'b0);
		tick(1'b1, c_d00, 1'b0, 10'h000);
		chk_tx(1'b1, 10'h0fa, 1'b1);
		tick(1'b1, c_k285, 1'b0, 10'h000);
		chk_tx(1'b1, 10'h18b, 1'b1);
		tick(1'b1, '{1'h0, 8'hf1}, 1'b0, 10'h000);
		chk_tx(1'b1, 10'h305, 1'b0);
		tick(1'b1, '{1'h0, 8'heb}, 1'b0, 10'h000);
		chk_tx(1'b1, 10'h237, 1'b1);
		tick(1'b1, '{1'h0, 8'he0}, 1'b0, 10'h000);
		chk_tx(1'b1, 10'h348, 1'b0);
		tick(1'b0, c_d00, 1'b0, 10'h000);
		chk_tx(1'b1, 10'h271, 1'b0);
		tick(1'b0, c_d00, 1'b0, 10'h000);
		chk_tx(1'b0, 10'h271, 1'b0);
	endtask

	// Good, wrong-disparity and unknown symbols from the deserialiser.
	task automatic scen_rx();
		do_reset();
		tick(1'b0, c_d00, 1'b1, 10'h274);
		tick(1'b0, c_d00, 1'b1, 10'h0fa);
		chk_rx(1'b1, c_d00, 1'b0, 1'b0, 1'b0);
		tick(1'b0, c_d00, 1'b1, 10'h274);
		chk_rx(1'b1, c_k285, 1'b0, 1'b0, 1'b1);
		tick(1'b0, c_d00, 1'b1, 10'h3ff);
		chk_rx(1'b1, c_err, 1'b1, 1'b0, 1'b1);
		tick(1'b0, c_d00, 1'b1, 10'h18b);
		chk_rx(1'b1, c_err, 1'b0, 1'b1, 1'b1);
		tick(1'b0, c_d00, 1'b1, 10'h305);
		chk_rx(1'b1, c_d00, 1'b0, 1'b0, 1'b1);
		tick(1'b0, c_d00, 1'b1, 10'h305);
		chk_rx(1'b1, c_k285, 1'b0, 1'b0, 1'b0);
		tick(1'b0, c_d00, 1'b0, 10'h000);
		chk_rx(1'b1, c_err, 1'b1, 1'b0, 1'b0);
		tick(1'b0, c_d00, 1'b0, 10'h000);
		chk_rx(1'b0, c_err, 1'b0, 1'b0, 1'b0);
	endtask

	// Loopback on while the deserialiser keeps offering unknown symbols.
	task automatic scen_lpbk();
		do_reset();
		lpbk_en <= 1'b1;
		tick(1'b1, c_d00, 1'b1, 10'h3ff);
		tick(1'b1, c_k285, 1'b1, 10'h3ff);
		tick(1'b0, c_d00, 1'b1, 10'h3ff);
		chk_rx(1'b1, c_d00, 1'b0, 1'b0, 1'b0);
		tick(1'b0, c_d00, 1'b1, 10'h3ff);
		chk_rx(1'b1, c_k285, 1'b0, 1'b0, 1'b1);
		tick(1'b0, c_d00, 1'b1, 10'h3ff);
		chk_rx(1'b0, c_k285, 1'b0, 1'b0, 1'b1);
		@(posedge mclk);
		lpbk_en <= 1'b0;
	endtask

	initial begin
		rst = 1'b1;
		tx_valid = 1'b0;
		tx_char = '0;
		cmd_valid = 1'b0;
		cmd_sym = '0;
		lpbk_en = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		n_cycles = 0;
		scen_tx();
		scen_rx();
		scen_lpbk();
		tally_and_finish();
	end
endmodule

//--- lcx_dec_lut.sv
// Reverse lookup of one received 10-bit symbol into a character.
// Assumes the caller supplies its own running disparity and registers
// the result; this module is purely combinational.
`timescale 1ns/1ps
module lcx_dec_lut
	import lcx_pkg::*;
(
	// Symbol and current receive disparity.
	input  logic [LCX_SYM_W-1:0] sym,
	input  logic                 rd,
	// Lookup result.
	output lcx_look_s            look
);

	// Every legal character is encoded from both disparities and compared;
	// a match only from the other disparity marks a disparity fault.
	function automatic lcx_look_s lookup(input logic [LCX_SYM_W-1:0] s,
		input logic cur_rd);
		lcx_char_s cand;
		lcx_code_s code;
		lcx_look_s res;
		res = '0;
		for (int i = 0; i < LCX_NDATA + LCX_NK; i++) begin
			if (i < LCX_NDATA) begin
				cand = '{k: 1'h0, data: i[7:0]};
			end else begin
				cand = '{k: 1'h1, data: LCX_K_LIST[i-LCX_NDATA]};
			end
			for (int r = 0; r < 2; r++) begin
				code = lcx_encode(cand, r[0]);
				if (code.sym == s) begin
					res.ch = cand;
					res.valid = 1'h1;
					if (r[0] == cur_rd) begin
						res.rd_ok = 1'h1;
					end
				end
			end
		end
		return res;
	endfunction

	assign look = lookup(sym, rd);

endmodule

//--- lcx_pkg.sv
// Package for the lane symbol codec: character and code types, the
// sub-block code tables, the error character and the shared encoder.
// Assumes a single lane clock domain; all users import the whole package.
package lcx_pkg;

	// A character as seen by the lane layer: control flag and byte.
	typedef struct packed {
		logic       k;
		logic [7:0] data;
	} lcx_char_s;

	// A coded symbol, abcdei in bits 9..4 and fghj in bits 3..0.
	typedef struct packed {
		logic       rd;
		logic [9:0] sym;
	} lcx_code_s;

	// Result of a reverse lookup of one received symbol.
	typedef struct packed {
		lcx_char_s ch;
		logic      valid;
		logic      rd_ok;
	} lcx_look_s;

	localparam int        LCX_SYM_W   = 10;
	localparam int        LCX_SYM_BAL = 5;
	localparam int        LCX_NDATA   = 256;
	localparam int        LCX_NK      = 12;
	localparam logic      LCX_RD_RST  = 1'h0;
	localparam lcx_char_s LCX_ERR_CHAR = '{k: 1'h1, data: 8'h00};

	// Negative-column codes of the 5B/6B sub-block, indexed by EDCBA.
	localparam logic [5:0] LCX_6B_NEG [32] = '{
		6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
		6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [5:0] LCX_K28_6B = 6'h0f;
	localparam logic [5:0] LCX_D07_6B = 6'h38;
	localparam logic [4:0] LCX_K28_X  = 5'h1c;

	// Negative-column codes of the 3B/4B sub-block, indexed by HGF.
	localparam logic [3:0] LCX_4B_NEG [8] = '{
		4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
	localparam logic [3:0] LCX_4B_ALT = 4'h7;
	localparam logic [2:0] LCX_Y3     = 3'h3;
	localparam logic [2:0] LCX_Y7     = 3'h7;

	// The twelve control codes that have a symbol.
	localparam logic [7:0] LCX_K_LIST [LCX_NK] = '{
		8'h1c, 8'h3c, 8'h5c, 8'h7c, 8'h9c, 8'hbc, 8'hdc, 8'hfc,
		8'hf7, 8'hfb, 8'hfd, 8'hfe};

	function automatic logic lcx_k_legal(input lcx_char_s c);
		logic ok;
		ok = 1'h0;
		for (int i = 0; i < LCX_NK; i++) begin
			if (c.data == LCX_K_LIST[i]) begin
				ok = 1'h1;
			end
		end
		return ok;
	endfunction

	// Encodes one character from running disparity rd (1 = positive).
	function automatic lcx_code_s lcx_encode(input lcx_char_s c,
		input logic rd);
		logic [4:0] x;
		logic [2:0] y;
		logic [5:0] c6;
		logic [5:0] s6;
		logic [3:0] c4;
		logic [3:0] s4;
		logic       rd6;
		logic       alt;
		logic       kv;
		logic       flip4;
		lcx_code_s  r;
		x = c.data[4:0];
		y = c.data[7:5];
		c6 = (c.k && x == LCX_K28_X) ? LCX_K28_6B : LCX_6B_NEG[x];
		s6 = (rd && ($countones(c6) != 3 || c6 == LCX_D07_6B)) ? ~c6 : c6;
		rd6 = ($countones(s6) > 3) ? 1'h1 :
			($countones(s6) < 3) ? 1'h0 : rd;
		// Alternate .7 keeps runs of equal bits to five or fewer.
		alt = (y == LCX_Y7) && (c.k ||
			(!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
			(rd6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
		kv = c.k && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6);
		c4 = alt ? LCX_4B_ALT : (kv ? ~LCX_4B_NEG[y] : LCX_4B_NEG[y]);
		flip4 = ($countones(c4) != 2) || y == LCX_Y3 || y == LCX_Y7 || kv;
		s4 = (rd6 && flip4) ? ~c4 : c4;
		r.sym = {s6, s4};
		r.rd = ($countones(s4) > 2) ? 1'h1 :
			($countones(s4) < 2) ? 1'h0 : rd6;
		return r;
	endfunction

endpackage

//--- lcx_serdes_model.sv
// Behavioural deserialiser side: presents received symbols to the codec.
// Assumes the bench commands each symbol at a rising mclk edge.
`timescale 1ns/1ps
module lcx_serdes_model
	import lcx_pkg::*;
(
	// Clock and reset.
	input  logic                 mclk,
	input  logic                 rst,
	// Commands from the bench.
	input  logic                 cmd_valid,
	input  logic [LCX_SYM_W-1:0] cmd_sym,
	// Symbols towards the codec.
	output logic                 rx_sym_valid,
	output logic [LCX_SYM_W-1:0] rx_sym
);
	logic [LCX_SYM_W-1:0] last_ff;

	// An idle symbol bus shows the inverse of the last symbol, never a copy.
	assign rx_sym_valid = cmd_valid;
	assign rx_sym       = cmd_valid ? cmd_sym : ~last_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			last_ff <= '0;
		end else if (cmd_valid) begin
			last_ff <= cmd_sym;
		end
	end
endmodule
